//--- hdl/aspc_consts.vh
`ifndef ASPC_CONSTS_VH
`define ASPC_CONSTS_VH
// ******************************************
// register byte offsets and reset values
// ******************************************
`define ASPC_OFF_BAUD 8'h00
`define ASPC_OFF_CTL 8'h04
`define ASPC_OFF_STAT 8'h08
`define ASPC_OFF_DATA 8'h0C
`define ASPC_OFF_PAIR 8'h10
`define ASPC_BAUD_RST 13'h0004
`define ASPC_CTL_RST 15'h0000
`define ASPC_THR_RST 9'h000
`define ASPC_FLG_RST 9'h180
`define ASPC_RX_MASK 9'h05F
`define ASPC_TX_MASK 9'h180
// ******************************************
// control field positions
// ******************************************
`define ASPC_C_LOOP 14
`define ASPC_C_TX_OPEN_DRAIN 13
`define ASPC_C_ILT 12
`define ASPC_C_PT 11
`define ASPC_C_PE 10
`define ASPC_C_M 9
`define ASPC_C_WAKE 8
`define ASPC_C_TIE 7
`define ASPC_C_TX_DONE_IRQ_EN 6
`define ASPC_C_RIE 5
`define ASPC_C_IDLE_IRQ_EN 4
`define ASPC_C_TE 3
`define ASPC_C_RE 2
`define ASPC_C_RWU 1
`define ASPC_C_SBK 0
// ******************************************
// status field positions
// ******************************************
`define ASPC_S_TX_HOLDING_EMPTY 8
`define ASPC_S_TC 7
`define ASPC_S_RX_HOLDING_FULL 6
`define ASPC_S_RAF 5
`define ASPC_S_IDLE 4
`define ASPC_S_OR 3
`define ASPC_S_NF 2
`define ASPC_S_FE 1
`define ASPC_S_PF 0
// ******************************************
// timing counts, in 16x ticks or bits
// ******************************************
`define ASPC_PH_LAST 4'hF
`define ASPC_SMP_A 4'h7
`define ASPC_SMP_B 4'h8
`define ASPC_SMP_C 4'h9
`define ASPC_RS_LO 4'h3
`define ASPC_RS_HI 4'hD
`define ASPC_STOP8 4'h9
`define ASPC_STOP9 4'hA
`define ASPC_LEN10 4'hA
`define ASPC_LEN11 4'hB
`define ASPC_IDL10 8'h9F
`define ASPC_IDL11 8'hAF
`define ASPC_ICNT_MAX 8'hFF
`endif

//--- hdl/aspc_top.v
// Behaviour
// - loopback feeds tx into rx, pin idles high
// - open-drain or push-pull tx pin when output
// - idle count from first one or after stop
// - parity on/odd for both directions, error flag
// - ten or eleven bit frames, msb parity
// - wake on idle line or address mark
// - four enables gate interrupt requests
// - transmitter keeps pin until frame ends
// - disabled receiver sets no flags, clears active flag
// - sleep ignores data, cleared on wakeup
// - break sends zero frames after current frame
// - status read then data access clears flags
// - flags set after status read survive
// - empty flag sets on load, overwrite allowed
// - done flag sets when all shifting ends
// - full flag and noise, framing, parity flags set together
// - active flag: start bit set, idle clear
// - idle flag rearmed only by full flag
// - overrun blocks transfers, keeps old data
// - three samples, majority, noise flag
// - zero stop bit sets framing error
// - one data address, ninth bit at 8
// - 16x sampling with edge resync
// - baud is clock over 32 times divisor
`include "aspc_consts.vh"
`default_nettype none
module aspc_top (
  // clock and reset
  input wire clk,
  input wire rstn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // serial pins
  input wire rxd,
  output reg txd_out,
  output reg txd_oe,
  // general purpose use of tx pin
  input wire gpio_out,
  input wire gpio_dir,
  // interrupt request
  output reg irq_req
);

// ******************************************
// registers and wires
// ******************************************
reg [12:0] baud_divisor_r;
reg [14:0] ctl_r;
reg [8:0] flg_r;
reg [8:0] snap_r;
reg [8:0] tx_holding_reg_r;
reg [8:0] rx_holding_reg_r;
reg idle_armed_r;
reg [13:0] bcnt_r;
reg tx_busy_r;
reg [3:0] tx_ph_r;
reg [3:0] tx_left_r;
reg [10:0] tx_sh_r;
reg pre_pend_r;
reg brk_pend_r;
reg te_d_r;
reg rx_busy_r;
reg [3:0] rx_ph_r;
reg [3:0] rx_idx_r;
reg rx_s7_r;
reg rx_s8_r;
reg rx_prev_r;
reg [8:0] rx_sh_r;
reg rx_nf_r;
reg [7:0] icnt_r;
reg [8:0] fset;
reg [8:0] fclr;
reg [31:0] rd_nxt;
reg map_ok;

wire loopback_sel = ctl_r[`ASPC_C_LOOP];
wire tx_open_drain = ctl_r[`ASPC_C_TX_OPEN_DRAIN];
wire idle_detect_long = ctl_r[`ASPC_C_ILT];
wire parity_odd = ctl_r[`ASPC_C_PT];
wire parity_on = ctl_r[`ASPC_C_PE];
wire long_frame = ctl_r[`ASPC_C_M];
wire wake_addr = ctl_r[`ASPC_C_WAKE];
wire tx_on = ctl_r[`ASPC_C_TE];
wire rx_on = ctl_r[`ASPC_C_RE];
wire rx_sleep = ctl_r[`ASPC_C_RWU];
wire send_break_ctl = ctl_r[`ASPC_C_SBK];
wire tx_holding_empty = flg_r[`ASPC_S_TX_HOLDING_EMPTY];
wire tx_done_flag = flg_r[`ASPC_S_TC];
wire rx_holding_full = flg_r[`ASPC_S_RX_HOLDING_FULL];
wire idle_flag = flg_r[`ASPC_S_IDLE];
wire overrun_flag = flg_r[`ASPC_S_OR];

// ******************************************
// apb decode
// ******************************************
// one wait state so read data and pready both come from flops
wire acc = psel & penable & pready;
wire wr_acc = acc & pwrite;
wire rd_acc = acc & ~pwrite;
wire a_pair = (paddr == `ASPC_OFF_PAIR);
wire st_rd = rd_acc & ((paddr == `ASPC_OFF_STAT) | a_pair);
wire dt_rd = rd_acc & ((paddr == `ASPC_OFF_DATA) | a_pair);
wire dt_wr = wr_acc & (paddr == `ASPC_OFF_DATA);
wire ctl_wr = wr_acc & (paddr == `ASPC_OFF_CTL);

// read mux and address map
always @*
begin
  map_ok = 1'b1;
  case (paddr)
    `ASPC_OFF_BAUD: rd_nxt = {19'h0_0000, baud_divisor_r};
    `ASPC_OFF_CTL: rd_nxt = {17'h0_0000, ctl_r};
    `ASPC_OFF_STAT: rd_nxt = {23'h00_0000, flg_r};
    `ASPC_OFF_DATA: rd_nxt = {23'h00_0000, rx_holding_reg_r};
    `ASPC_OFF_PAIR: rd_nxt = {7'h00, flg_r, 7'h00, rx_holding_reg_r};
    default:
    begin
      rd_nxt = 32'h0000_0000;
      map_ok = 1'b0;
    end
  endcase
end

// bus answer flops
always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    pready <= 1'b0;
    prdata <= 32'h0000_0000;
    pslverr <= 1'b0;
  end
  else
  begin
    pready <= psel & penable & ~pready;
    prdata <= rd_nxt;
    pslverr <= psel & penable & ~pready & ~map_ok;
  end
end

// ******************************************
// baud generator, 16x tick
// ******************************************
// 16x rate is clk / (2 * divisor), so bits run at clk / (32 * divisor)
wire [13:0] bmod = {baud_divisor_r, 1'b0};
// compare with >= so a divisor cut below the running count cannot stall the tick
wire tick = (baud_divisor_r != 13'h0000) & (bcnt_r + 14'h0001 >= bmod);

always @(posedge clk or negedge rstn)
begin
  if (!rstn)
    bcnt_r <= 14'h0000;
  else if (tick | (baud_divisor_r == 13'h0000))
    bcnt_r <= 14'h0000;
  else
    bcnt_r <= bcnt_r + 14'h0001;
end

// ******************************************
// transmitter
// ******************************************
wire [8:0] td = tx_holding_reg_r;
wire par9 = (^td[7:0]) ^ parity_odd;
wire par8 = (^td[6:0]) ^ parity_odd;
// msb of the data field carries parity when enabled
wire [8:0] fld9 = {parity_on ? par9 : td[8], td[7:0]};
wire [8:0] fld8 = {1'b1, parity_on ? par8 : td[7], td[6:0]};
wire [10:0] frame = {1'b1, long_frame ? fld9 : fld8, 1'b0};
wire [3:0] flen = long_frame ? `ASPC_LEN11 : `ASPC_LEN10;
wire brk_req = send_break_ctl | brk_pend_r;
wire tx_free = tick & ~tx_busy_r & tx_on;
wire ld_brk = tx_free & brk_req;
wire ld_pre = tx_free & ~brk_req & pre_pend_r;
wire ld_dat = tx_free & ~brk_req & ~pre_pend_r & ~tx_holding_empty;
wire tx_load = ld_brk | ld_pre | ld_dat;
wire tx_last = tick & tx_busy_r & (tx_ph_r == `ASPC_PH_LAST) & (tx_left_r == 4'h1);
wire tx_fin = tx_last & tx_holding_empty & ~brk_req & ~pre_pend_r;
wire tx_bit = tx_busy_r ? tx_sh_r[0] : 1'b1;
wire tx_own = tx_on | tx_busy_r;

// shifter and queue of break and preamble frames
always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    tx_busy_r <= 1'b0;
    tx_ph_r <= 4'h0;
    tx_left_r <= 4'h0;
    tx_sh_r <= 11'h7FF;
    pre_pend_r <= 1'b0;
    brk_pend_r <= 1'b0;
    te_d_r <= 1'b0;
  end
  else
  begin
    te_d_r <= tx_on;
    // a short break pulse is remembered so at least one break frame goes
    brk_pend_r <= ld_brk ? 1'b0 : (brk_pend_r | send_break_ctl);
    if (tx_on & ~te_d_r)
      pre_pend_r <= 1'b1;
    else if (ld_pre)
      pre_pend_r <= 1'b0;
    if (tx_load)
    begin
      tx_busy_r <= 1'b1;
      tx_ph_r <= 4'h0;
      tx_left_r <= flen;
      if (ld_brk)
        tx_sh_r <= 11'h000;
      else if (ld_pre)
        tx_sh_r <= 11'h7FF;
      else
        tx_sh_r <= frame;
    end
    else if (tick & tx_busy_r)
    begin
      tx_ph_r <= tx_ph_r + 4'h1;
      if (tx_ph_r == `ASPC_PH_LAST)
      begin
        tx_sh_r <= {1'b1, tx_sh_r[10:1]};
        tx_left_r <= tx_left_r - 4'h1;
        // frame in progress finishes even after enable drops
        if (tx_left_r == 4'h1)
          tx_busy_r <= 1'b0;
      end
    end
  end
end

// ******************************************
// receiver
// ******************************************
// loopback feeds the shifter output straight back to the receiver
wire rx_in = loopback_sel ? tx_bit : rxd;
wire rx_tick = tick & rx_on;
wire vote = (rx_s7_r & rx_s8_r) | (rx_s7_r & rx_in) | (rx_s8_r & rx_in);
wire noisy = ~((rx_s7_r == rx_s8_r) & (rx_s8_r == rx_in));
wire smp_c = rx_tick & rx_busy_r & (rx_ph_r == `ASPC_SMP_C);
wire [3:0] stop_idx = long_frame ? `ASPC_STOP9 : `ASPC_STOP8;
wire false_start = smp_c & (rx_idx_r == 4'h0) & vote;
wire frm_done = smp_c & (rx_idx_r == stop_idx);
wire start_evt = rx_tick & ~rx_busy_r & ~rx_in;
wire edge_seen = rx_tick & rx_busy_r & (rx_in != rx_prev_r);
wire rs_late = edge_seen & (rx_ph_r > `ASPC_RS_HI);
wire rs_early = edge_seen & (rx_ph_r < `ASPC_RS_LO);
wire [8:0] rx_fld = long_frame ? rx_sh_r : {1'b0, rx_sh_r[7:0]};
wire amark = long_frame ? rx_sh_r[8] : rx_sh_r[7];
wire par_bad = parity_on & ((^rx_fld) ^ parity_odd);
wire addr_wake = frm_done & rx_sleep & wake_addr & amark;
wire rx_live = ~rx_sleep | addr_wake;
wire xfer_ok = frm_done & rx_live & ~overrun_flag;
wire xfer = xfer_ok & ~rx_holding_full;
wire ovr = xfer_ok & rx_holding_full;

// bit timing, three samples per bit
always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    rx_busy_r <= 1'b0;
    rx_ph_r <= 4'h0;
    rx_idx_r <= 4'h0;
    rx_s7_r <= 1'b1;
    rx_s8_r <= 1'b1;
    rx_prev_r <= 1'b1;
    rx_sh_r <= 9'h000;
    rx_nf_r <= 1'b0;
  end
  else if (!rx_on)
    rx_busy_r <= 1'b0;
  else if (rx_tick)
  begin
    rx_prev_r <= rx_in;
    if (!rx_busy_r)
    begin
      if (!rx_in)
      begin
        rx_busy_r <= 1'b1;
        rx_ph_r <= 4'h0;
        rx_idx_r <= 4'h0;
        rx_nf_r <= 1'b0;
      end
    end
    else
    begin
      // an edge near a boundary realigns the bit phase
      if (rs_late | rs_early)
        rx_ph_r <= 4'h0;
      else
        rx_ph_r <= rx_ph_r + 4'h1;
      if (rs_late | (rx_ph_r == `ASPC_PH_LAST))
        rx_idx_r <= rx_idx_r + 4'h1;
      if (rx_ph_r == `ASPC_SMP_A)
        rx_s7_r <= rx_in;
      if (rx_ph_r == `ASPC_SMP_B)
        rx_s8_r <= rx_in;
      if (rx_ph_r == `ASPC_SMP_C)
      begin
        // noise on a rejected start bit is dropped with it
        if (false_start | frm_done)
          rx_busy_r <= 1'b0;
        else
          rx_nf_r <= rx_nf_r | noisy;
        if ((rx_idx_r != 4'h0) & ~frm_done)
          rx_sh_r[rx_idx_r - 4'h1] <= vote;
      end
    end
  end
end

// idle line: a frame length of ones, counted at 16x
wire [7:0] ithr = long_frame ? `ASPC_IDL11 : `ASPC_IDL10;
wire icnt_rst = ~rx_in | (idle_detect_long & rx_busy_r);
wire idle_evt = rx_tick & ~icnt_rst & (icnt_r == ithr);

always @(posedge clk or negedge rstn)
begin
  if (!rstn)
    icnt_r <= 8'h00;
  else if (!rx_on)
    icnt_r <= 8'h00;
  else if (rx_tick)
  begin
    if (icnt_rst)
      icnt_r <= 8'h00;
    else if (icnt_r != `ASPC_ICNT_MAX)
      icnt_r <= icnt_r + 8'h01;
  end
end

// ******************************************
// status flags
// ******************************************
wire idle_wake = idle_evt & rx_sleep & ~wake_addr;

// hardware sets win over clears in the same cycle
always @*
begin
  fset = 9'h000;
  fclr = 9'h000;
  fset[`ASPC_S_TX_HOLDING_EMPTY] = ld_dat;
  fset[`ASPC_S_TC] = tx_fin;
  fset[`ASPC_S_RX_HOLDING_FULL] = xfer;
  fset[`ASPC_S_NF] = xfer & (rx_nf_r | noisy);
  fset[`ASPC_S_FE] = xfer & ~vote;
  fset[`ASPC_S_PF] = xfer & par_bad;
  fset[`ASPC_S_OR] = ovr;
  fset[`ASPC_S_RAF] = start_evt & ~rx_sleep;
  fset[`ASPC_S_IDLE] = idle_evt & ~rx_sleep & idle_armed_r;
  // only flags seen set by a status read are cleared
  if (dt_rd)
    fclr = (a_pair ? flg_r : snap_r) & `ASPC_RX_MASK;
  if (dt_wr)
    fclr = fclr | (snap_r & `ASPC_TX_MASK);
  fclr[`ASPC_S_TC] = fclr[`ASPC_S_TC] | tx_load;
  fclr[`ASPC_S_RAF] = idle_evt | ~rx_on;
end

// flags, snapshot of the last status read, rearm of idle
always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    flg_r <= `ASPC_FLG_RST;
    snap_r <= 9'h000;
    idle_armed_r <= 1'b1;
  end
  else
  begin
    flg_r <= (flg_r & ~fclr) | fset;
    if (st_rd)
      snap_r <= flg_r;
    else
      snap_r <= snap_r & ~fclr;
    if (fset[`ASPC_S_RX_HOLDING_FULL])
      idle_armed_r <= 1'b1;
    else if (fset[`ASPC_S_IDLE])
      idle_armed_r <= 1'b0;
  end
end

// ******************************************
// software registers and data holding
// ******************************************
always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    baud_divisor_r <= `ASPC_BAUD_RST;
    ctl_r <= `ASPC_CTL_RST;
    tx_holding_reg_r <= `ASPC_THR_RST;
    rx_holding_reg_r <= `ASPC_THR_RST;
  end
  else
  begin
    if (wr_acc & (paddr == `ASPC_OFF_BAUD))
      baud_divisor_r <= pwdata[12:0];
    if (ctl_wr)
      ctl_r <= pwdata[14:0];
    else if (addr_wake | idle_wake)
      ctl_r[`ASPC_C_RWU] <= 1'b0;
    // a write before the flag clears just replaces the pending word
    if (dt_wr)
      tx_holding_reg_r <= pwdata[8:0];
    // old word stays while overrun holds
    if (xfer)
      rx_holding_reg_r <= rx_fld;
  end
end

// ******************************************
// pin drive and interrupt request
// ******************************************
wire pin_bit = loopback_sel ? 1'b1 : tx_bit;

always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    txd_out <= 1'b1;
    txd_oe <= 1'b0;
    irq_req <= 1'b0;
  end
  else
  begin
    if (tx_own)
    begin
      txd_out <= tx_open_drain ? 1'b0 : pin_bit;
      txd_oe <= tx_open_drain ? ~pin_bit : 1'b1;
    end
    else
    begin
      // open drain applies only while the pin is an output
      txd_out <= tx_open_drain ? 1'b0 : gpio_out;
      txd_oe <= gpio_dir & (tx_open_drain ? ~gpio_out : 1'b1);
    end
    // sleeping receiver raises no receive request
    irq_req <= (tx_holding_empty & ctl_r[`ASPC_C_TIE]) |
      (tx_done_flag & ctl_r[`ASPC_C_TX_DONE_IRQ_EN]) |
      (rx_holding_full & ctl_r[`ASPC_C_RIE] & ~rx_sleep) |
      (idle_flag & ctl_r[`ASPC_C_IDLE_IRQ_EN] & ~rx_sleep);
  end
end

endmodule
`default_nettype wire

//--- verification/aspc_top_sva.sv
`default_nettype none
module aspc_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pin and interrupt
  input wire logic txd_out,
  input wire logic txd_oe,
  input wire logic gpio_out,
  input wire logic gpio_dir,
  input wire logic irq_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [14:0] ctl_r;
  logic te_seen_r;
  logic re_seen_r;
  logic live_r;
  wire logic done_w;
  wire logic st_rd;
  assign done_w = psel && penable && pready;
  assign st_rd = done_w && !pwrite && paddr == 8'h08;
  // control shadow; live_r skips the first edge, whose pin still shows reset
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctl_r <= 15'h0000;
      te_seen_r <= 1'b0;
      re_seen_r <= 1'b0;
      live_r <= 1'b0;
    end
    else
    begin
      live_r <= 1'b1;
      if (done_w && pwrite && paddr == 8'h04)
      begin
        ctl_r <= pwdata[14:0];
        te_seen_r <= te_seen_r | pwdata[3];
        re_seen_r <= re_seen_r | pwdata[2];
      end
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ****
  // properties
  // ****
  a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  a_loop_high: assert property (
    live_r && ctl_r[14] && ctl_r[3] && $past(ctl_r[14]) |-> txd_out && txd_oe)
    else $error("loopback pin not held high");
  a_od_low: assert property (
    ctl_r[13] && $past(ctl_r[13]) && ctl_r[3] && !ctl_r[14] |-> !(txd_oe && txd_out))
    else $error("open drain pin driven high");
  a_gpio_pin: assert property (
    live_r && !te_seen_r && !ctl_r[13] |->
    txd_oe == $past(gpio_dir) && (!txd_oe || txd_out == $past(gpio_out)))
    else $error("pin does not follow gpio");
  a_irq_off: assert property (
    ctl_r[7:4] == 4'h0 && $past(ctl_r[7:4]) == 4'h0 |-> !irq_req)
    else $error("interrupt with all enables off");
  a_irq_on: assert property (
    ctl_r[7] && $past(ctl_r[7]) && !te_seen_r |-> irq_req)
    else $error("tx empty interrupt missing");
  a_tx_idle_flags: assert property (
    st_rd && !te_seen_r |-> prdata[8:7] == 2'b11)
    else $error("tx flags not set while idle");
  a_rx_quiet: assert property (
    st_rd && !re_seen_r |-> prdata[6:0] == 7'h00)
    else $error("rx flags with receiver never on");
  a_data_pad: assert property (
    done_w && !pwrite && paddr == 8'h0C |-> prdata[31:9] == 23'h00_0000)
    else $error("data read upper bits not zero");
  c_data_rd: cover property (done_w && !pwrite && paddr == 8'h0C);
  c_loop: cover property (ctl_r[14] && txd_oe);
  c_od: cover property (ctl_r[13] && txd_oe && !txd_out);
endmodule
bind aspc_top aspc_chk i_aspc_chk (
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .txd_out(txd_out), .txd_oe(txd_oe), .gpio_out(gpio_out),
  .gpio_dir(gpio_dir), .irq_req(irq_req)
);
`default_nettype wire

//--- verification/aspc_remote.sv
`default_nettype none
module aspc_remote #(
  parameter int BIT_CLKS = 32
) (
  // clock
  input wire logic clk,
  // serial lines
  input wire logic line_in,
  output var logic rxd,
  // field bits per frame
  input wire logic [3:0] nb
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] got_w;
  logic [8:0] sh;
  logic got_stp;
  int got_n;
  initial
  begin
    rxd = 1'b1;
    got_n = 0;
  end
  // one frame lsb first, then a mark bit so frames never touch
  task automatic send(input logic [8:0] w, input logic stp);
    rxd <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk);
    for (int i = 0; i < nb; i++)
    begin
      rxd <= w[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    rxd <= stp;
    repeat (BIT_CLKS) @(posedge clk);
    rxd <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk);
  endtask
  // capture frames mid-bit; a start glitch shorter than half a bit is dropped
  always
  begin
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge clk);
    if (line_in == 1'b0)
    begin
      sh = 9'h000;
      for (int i = 0; i < nb; i++)
      begin
        repeat (BIT_CLKS) @(posedge clk);
        sh[i] = line_in;
      end
      repeat (BIT_CLKS) @(posedge clk);
      got_stp = line_in;
      got_w = sh;
      got_n++;
    end
  end
endmodule
`default_nettype wire

//--- verification/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic gpio_out = 1'b1;
  logic gpio_dir = 1'b1;
  logic [3:0] nb = 4'h8;
  logic [31:0] rd_d;
  logic rd_e;
  int mismatches = 0;
  int checks_done = 0;
  int n0;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire logic rxd;
  wire logic txd_out;
  wire logic txd_oe;
  wire logic irq_req;
  wire logic pin;
  // pull-up holds the line at mark when nobody drives it
  assign pin = txd_oe ? txd_out : 1'b1;
  always #4 clk = ~clk;
  aspc_top i_aspc_top (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd_out(txd_out), .txd_oe(txd_oe),
    .gpio_out(gpio_out), .gpio_dir(gpio_dir), .irq_req(irq_req)
  );
  aspc_remote i_aspc_remote (.clk(clk), .line_in(pin), .rxd(rxd), .nb(nb));
  // ****
  // tasks
  // ****
  task automatic end_sim;
    if (mismatches == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; pready is read before the edge's own updates land
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd_d = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // status then data read drops every receive flag seen except rx active
  task automatic fl;
    rd(8'h08);
    rd(8'h0C);
  endtask
  task automatic xmit(input logic [8:0] d);
    rd(8'h08);
    wr(8'h0C, 32'(d));
  endtask
  task automatic wait_rem;
    n0 = i_aspc_remote.got_n;
    for (int i = 0; i < 3000 && i_aspc_remote.got_n == n0; i++) @(posedge clk);
    if (i_aspc_remote.got_n == n0)
    begin
      mismatches++;
      $display("MISMATCH t=%0t no frame seen at remote", $time);
    end
  endtask
  task automatic wst(input logic [31:0] m);
    for (int i = 0; i < 300; i++)
    begin
      rd(8'h08);
      if ((rd_d & m) != 32'h0000_0000) break;
    end
    if ((rd_d & m) == 32'h0000_0000)
    begin
      mismatches++;
      $display("MISMATCH t=%0t status bit never set", $time);
    end
  endtask
  // watchdog, several times the expected run
  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches++;
    end_sim;
  end
  // ****
  // test sequence
  // ****
  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(8'h00); chk(rd_d, 32'h0000_0004);
    rd(8'h04); chk(rd_d, 32'h0000_0000);
    rd(8'h08); chk(rd_d, 32'h0000_0180);
    rd(8'h40); chk(32'(rd_e), 32'h0000_0001);
    gpio_out <= 1'b0;
    wr(8'h04, 32'h0000_0080);
    repeat (2) @(posedge clk);
    chk(32'(irq_req), 32'h0000_0001);
    wr(8'h04, 32'h0000_0000);
    wr(8'h00, 32'h0000_0001);
    wr(8'h04, 32'h0000_000C);
    repeat (330) @(posedge clk);
    xmit(9'h0A5);
    rd(8'h08); chk(rd_d & 32'h0000_0180, 32'h0000_0100);
    wait_rem; chk(32'(i_aspc_remote.got_w), 32'h0000_00A5);
    wst(32'h0000_0080); chk(rd_d & 32'h0000_0180, 32'h0000_0180);
    // receive, then idle line after one frame of marks
    fl;
    i_aspc_remote.send(9'h03C, 1'b1);
    rd(8'h08); chk(rd_d & 32'h0000_007F, 32'h0000_0060);
    rd(8'h0C); chk(rd_d, 32'h0000_003C);
    repeat (400) @(posedge clk);
    rd(8'h08); chk(rd_d & 32'h0000_007F, 32'h0000_0010);
    // even then odd parity, good and bad, both ways; idle bit masked
    for (int pt = 0; pt < 2; pt++)
    begin
      wr(8'h04, 32'h0000_040C | (32'(pt) << 11));
      fl;
      i_aspc_remote.send({1'b0, pt[0], 7'h14}, 1'b1);
      rd(8'h08); chk(rd_d & 32'h0000_006F, 32'h0000_0060);
      fl;
      i_aspc_remote.send({1'b0, ~pt[0], 7'h14}, 1'b1);
      rd(8'h08); chk(rd_d & 32'h0000_006F, 32'h0000_0061);
      fl;
      xmit(9'h014);
      wait_rem; chk(32'(i_aspc_remote.got_w), 32'h0000_0014 | (32'(pt) << 7));
    end
    wr(8'h04, 32'h0000_000C);
    fl;
    i_aspc_remote.send(9'h055, 1'b0);
    rd(8'h08); chk(rd_d & 32'h0000_006F, 32'h0000_0062);
    fl;
    // second word arrives before the first is taken
    i_aspc_remote.send(9'h0A1, 1'b1);
    i_aspc_remote.send(9'h0B2, 1'b1);
    rd(8'h08); chk(rd_d & 32'h0000_006F, 32'h0000_0068);
    rd(8'h0C); chk(rd_d, 32'h0000_00A1);
    fl;
    wr(8'h04, 32'h0000_020C);
    nb <= 4'h9;
    i_aspc_remote.send(9'h1A5, 1'b1);
    rd(8'h08); chk(rd_d & 32'h0000_006F, 32'h0000_0060);
    rd(8'h0C); chk(rd_d, 32'h0000_01A5);
    // long-word read drops receive flags only; rx full raises the request
    wr(8'h04, 32'h0000_022C);
    i_aspc_remote.send(9'h0C3, 1'b1);
    chk(32'(irq_req), 32'h0000_0001);
    rd(8'h10); chk(rd_d & 32'h006F_01FF, 32'h0060_00C3);
    rd(8'h08); chk(rd_d & 32'h0000_01CF, 32'h0000_0180);
    chk(32'(irq_req), 32'h0000_0000);
    nb <= 4'h8;
    // let the line go idle so rx active is clear before sleeping
    repeat (400) @(posedge clk);
    // sleep until an address mark, then until an idle line
    wr(8'h04, 32'h0000_010E);
    i_aspc_remote.send(9'h011, 1'b1);
    rd(8'h08); chk(rd_d & 32'h0000_006F, 32'h0000_0000);
    i_aspc_remote.send(9'h081, 1'b1);
    rd(8'h08); chk(rd_d & 32'h0000_0040, 32'h0000_0040);
    rd(8'h04); chk(rd_d, 32'h0000_010C);
    fl;
    wr(8'h04, 32'h0000_000E);
    i_aspc_remote.send(9'h011, 1'b1);
    repeat (400) @(posedge clk);
    rd(8'h04); chk(rd_d, 32'h0000_000C);
    fl;
    // loopback keeps the wire quiet
    wr(8'h04, 32'h0000_400C);
    n0 = i_aspc_remote.got_n;
    xmit(9'h05A);
    wst(32'h0000_0040);
    rd(8'h0C); chk(rd_d, 32'h0000_005A);
    chk(32'(i_aspc_remote.got_n), 32'(n0));
    wr(8'h04, 32'h0000_0008);
    i_aspc_remote.send(9'h077, 1'b1);
    rd(8'h08); chk(rd_d & 32'h0000_006F, 32'h0000_0000);
    // break on an open-drain pin, then hand the pin back
    wr(8'h04, 32'h0000_200D);
    wait_rem; chk(32'({i_aspc_remote.got_stp, i_aspc_remote.got_w}), 32'h0000_0000);
    // gpio drives high, so only a pin handed back to gpio can read back as 3
    gpio_out <= 1'b1;
    wr(8'h04, 32'h0000_0000);
    chk(32'({txd_oe, txd_out}), 32'h0000_0002);
    repeat (400) @(posedge clk);
    chk(32'({txd_oe, txd_out}), 32'h0000_0003);
    end_sim;
  end
endmodule
`default_nettype wire
